// File: ccp_compare_unit.sv
/*
  One compare/PWM unit: match detection, pin latch, trigger pulse and
  the PWM duty double buffer.
  Assumes count and value are stable synchronous signals of i_ref_clk.
*/
`timescale 1ns/1ps
module ccp_compare_unit (
  // clock, reset, enable
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  input wire logic i_ce,
  // configuration
  input wire logic [3:0] i_mode,
  input wire logic [3:0] i_new_mode,
  input wire logic i_mode_wr,
  input wire logic i_ctl_zero,
  input wire logic [15:0] i_value,
  input wire logic [9:0] i_duty,
  // time bases
  input wire logic [15:0] i_count,
  input wire logic [9:0] i_pwm_base,
  input wire logic i_pwm_period,
  // results
  output logic o_match,
  output logic o_trig,
  output logic o_latch,
  output logic o_drive,
  output logic [9:0] o_duty_buf
);
  typedef struct packed {
    logic prev_eq;        // equality seen last cycle
    logic match;          // one-cycle match pulse
    logic trig;           // one-cycle trigger pulse
    logic latch;          // unit output latch
    logic drive;          // unit owns the pin
    logic [9:0] duty_buf; // duty seen by the running period
  } unit_state_t;

  unit_state_t r_reg;
  unit_state_t r_next;
  logic is_cmp;
  logic is_pwm;
  logic eq;
  logic hit;

  // next state
  always_comb begin
    r_next = r_reg;
    is_cmp = (i_mode[3:2] == ccp_pkg::MODE_CMP_PFX) || (i_mode == ccp_pkg::MODE_TOGGLE);
    is_pwm = (i_mode[3:2] == ccp_pkg::MODE_PWM_PFX);
    eq = (i_count == i_value); // full width compare
    // only the first equal cycle counts
    hit = is_cmp && eq && !r_reg.prev_eq;
    r_next.prev_eq = eq;
    r_next.match = hit; // flag raised for every compare code
    r_next.trig = hit && (i_mode == ccp_pkg::MODE_TRIGGER);
    r_next.drive = (is_cmp && (i_mode != ccp_pkg::MODE_SW_INT)) || is_pwm;
    if (i_mode_wr) begin
      // a control write sets up the latch for the new mode
      if (i_ctl_zero || i_new_mode == ccp_pkg::MODE_SET_HI) begin
        r_next.latch = 1'b0;
      end else if (i_new_mode == ccp_pkg::MODE_SET_LO) begin
        r_next.latch = 1'b1;
      end
    end else if (hit) begin
      // pin action
      unique case (i_mode)
        ccp_pkg::MODE_TOGGLE: r_next.latch = !r_reg.latch;
        ccp_pkg::MODE_SET_HI: r_next.latch = 1'b1;
        ccp_pkg::MODE_SET_LO: r_next.latch = 1'b0;
        default: r_next.latch = r_reg.latch; // soft interrupt and trigger leave it
      endcase
    end else if (is_pwm) begin
      // duty is latched only at the period edge so no glitch
      if (i_pwm_period) begin
        r_next.duty_buf = i_duty;
        r_next.latch = (i_duty != '0);
      end else if (i_pwm_base == r_reg.duty_buf) begin
        r_next.latch = 1'b0;
      end
    end
  end

  // state register, frozen while the enable is low
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      r_reg <= '0;
    end else if (i_ce) begin
      r_reg <= r_next;
    end
  end

  assign o_match = r_reg.match;
  assign o_trig = r_reg.trig;
  assign o_latch = r_reg.latch;
  assign o_drive = r_reg.drive;
  assign o_duty_buf = r_reg.duty_buf;
endmodule

// File: ccp_device_end.sv
/*
  Device end: register file of the two compare/PWM units, timer select,
  match flags with interrupt enables, special trigger fan-out and pins.
  Assumes the partner end drives the link synchronously to i_ref_clk and
  that the register port never issues read and write at once.
*/
// Added by the designer: the address-and-strobe port and the register offsets.
// Operation
// - compare 16-bit value against selected timer count
// - mode field chooses high, low, toggle, none
// - flag set together with the pin action
// - software clears pin direction bit first
// - zero control write forces unit latch low
// - timer must run synchronously for compares
// - soft interrupt code leaves pin alone
// - interrupt only when flag and enable set
// - trigger code emits internal trigger on match
// - trigger clears the unit's selected timer
// - unit two trigger starts enabled converter
// - PWM mode gives ten-bit duty waveform
// - software clears direction bit for PWM
// - unimplemented register bits read zero
// - software keeps absent variant bits cleared
// - code 1001 starts high, goes low on match
// - third timer control bits select time base
`timescale 1ns/1ps
module ccp_device_end (
  // link to the partner end
  ccp_link_if.dev link,
  // clock, reset, enable
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  input wire logic i_ce,
  // unit pins
  output logic [1:0] o_pin,
  output logic [1:0] o_pin_oe,
  // interrupt
  output logic o_irq
);
  localparam int NU = ccp_pkg::NUM_UNITS;

  typedef struct packed {
    logic [7:0] t3;            // third timer control and select bits
    logic [1:0][15:0] val;     // compare values
    logic [1:0][7:0] con;      // unit control registers
    logic [1:0] flag;          // sticky match flags
    logic [1:0] en;            // match interrupt enables
    logic [7:0] rdata;         // read answer, one cycle after strobe
    logic irq;                 // interrupt level
    logic clr1;                // first timer clear pulse
    logic clr3;                // third timer clear pulse
    logic adc;                 // converter start pulse
    logic [1:0] pin;           // pin level
    logic [1:0] pin_oe;        // pin drive enable
  } dev_state_t;

  dev_state_t r_reg;
  dev_state_t r_next;

  // per unit wires between the register file and the unit cores
  logic [NU-1:0] u_match;
  logic [NU-1:0] u_trig;
  logic [NU-1:0] u_latch;
  logic [NU-1:0] u_drive;
  logic [NU-1:0] u_mode_wr;
  logic [NU-1:0] u_ctl_zero;
  logic [NU-1:0][9:0] u_dbuf;
  logic [NU-1:0][15:0] u_count;
  logic [NU-1:0][9:0] u_duty;

  // one core per unit
  generate
    for (genvar g = 0; g < NU; g++) begin : g_unit
      // time base chosen by the third timer's select bits
      assign u_count[g] = ccp_pkg::uses_timer3(g, r_reg.t3) ?
                          link.third_timer_count : link.first_timer_count;
      assign u_mode_wr[g] = link.reg_wr && (link.reg_addr == ccp_pkg::REG_CON[g]);
      assign u_ctl_zero[g] = (link.reg_wdata == '0);
      // ten-bit duty: low value byte above the two control bits
      assign u_duty[g] = {r_reg.val[g][7:0], r_reg.con[g][ccp_pkg::CON_DUTY_LSB +: 2]};
      ccp_compare_unit u_core (
        .i_ref_clk(i_ref_clk),
        .i_rstn(i_rstn),
        .i_ce(i_ce),
        .i_mode(r_reg.con[g][ccp_pkg::CON_MODE_LSB +: ccp_pkg::MODE_W]),
        .i_new_mode(link.reg_wdata[ccp_pkg::CON_MODE_LSB +: ccp_pkg::MODE_W]),
        .i_mode_wr(u_mode_wr[g]),
        .i_ctl_zero(u_ctl_zero[g]),
        .i_value(r_reg.val[g]),
        .i_duty(u_duty[g]),
        .i_count(u_count[g]),
        .i_pwm_base(link.pwm_base),
        .i_pwm_period(link.pwm_period),
        .o_match(u_match[g]),
        .o_trig(u_trig[g]),
        .o_latch(u_latch[g]),
        .o_drive(u_drive[g]),
        .o_duty_buf(u_dbuf[g])
      );
    end
  endgenerate

  // true when the unit runs in PWM mode
  function automatic logic in_pwm(input logic [7:0] con);
    return con[ccp_pkg::CON_MODE_LSB + 2 +: 2] == ccp_pkg::MODE_PWM_PFX;
  endfunction

  // register file, flags, trigger fan-out and pin selection
  always_comb begin
    logic [1:0] clr_mask;
    clr_mask = '0;
    r_next = r_reg;
    r_next.clr1 = 1'b0;
    r_next.clr3 = 1'b0;
    r_next.adc = 1'b0;
    r_next.rdata = '0;
    // writes
    if (link.reg_wr) begin
      if (link.reg_addr == ccp_pkg::REG_T3) begin
        r_next.t3 = link.reg_wdata;
      end
      if (link.reg_addr == ccp_pkg::REG_FLAG_CLR) begin
        clr_mask = link.reg_wdata[1:0];
      end
      if (link.reg_addr == ccp_pkg::REG_FLAG_EN) begin
        r_next.en = link.reg_wdata[1:0];
      end
      for (int u = 0; u < NU; u++) begin
        if (link.reg_addr == ccp_pkg::REG_LO[u]) begin
          r_next.val[u][7:0] = link.reg_wdata;
        end
        // high byte is read-only while the unit runs PWM
        if (link.reg_addr == ccp_pkg::REG_HI[u] && !in_pwm(r_reg.con[u])) begin
          r_next.val[u][15:8] = link.reg_wdata;
        end
        if (link.reg_addr == ccp_pkg::REG_CON[u]) begin
          // absent bits never stored, so they read zero
          r_next.con[u] = link.reg_wdata & ccp_pkg::CON_MASK[u];
        end
      end
    end
    // a match in the clearing cycle survives, set wins over clear
    r_next.flag = (r_reg.flag & ~clr_mask) | u_match;
    // trigger fan-out, one pulse per match
    for (int u = 0; u < NU; u++) begin
      if (u_trig[u]) begin
        // clear whichever timer the unit uses now
        if (ccp_pkg::uses_timer3(u, r_reg.t3)) begin
          r_next.clr3 = 1'b1;
        end else begin
          r_next.clr1 = 1'b1;
        end
        // only the second unit starts the converter
        if (u == 1 && link.adc_enabled) begin
          r_next.adc = 1'b1;
        end
      end
      // unit latch or port latch on the pin
      r_next.pin[u] = u_drive[u] ? u_latch[u] : link.port_latch[u];
      // direction is software's job, the pin only follows it
      r_next.pin_oe[u] = !link.pin_direction_bit[u];
    end
    // level interrupt from flag and enable together
    r_next.irq = |(r_next.flag & r_next.en);
    // reads, answer in the next cycle; unmapped reads give zero
    if (link.reg_rd) begin
      if (link.reg_addr == ccp_pkg::REG_T3) begin
        r_next.rdata = r_reg.t3;
      end
      if (link.reg_addr == ccp_pkg::REG_FLAG) begin
        r_next.rdata = {6'h00, r_reg.flag};
      end
      if (link.reg_addr == ccp_pkg::REG_FLAG_EN) begin
        r_next.rdata = {6'h00, r_reg.en};
      end
      for (int u = 0; u < NU; u++) begin
        if (link.reg_addr == ccp_pkg::REG_LO[u]) begin
          r_next.rdata = r_reg.val[u][7:0];
        end
        if (link.reg_addr == ccp_pkg::REG_HI[u]) begin
          // in PWM the high byte shows the buffered duty
          r_next.rdata = in_pwm(r_reg.con[u]) ? u_dbuf[u][9:2] : r_reg.val[u][15:8];
        end
        if (link.reg_addr == ccp_pkg::REG_CON[u]) begin
          r_next.rdata = r_reg.con[u];
        end
      end
    end
  end

  // state register, frozen while the enable is low
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      r_reg <= '0;
    end else if (i_ce) begin
      r_reg <= r_next;
    end
  end

  // outputs straight from the state register
  assign o_pin = r_reg.pin;
  assign o_pin_oe = r_reg.pin_oe;
  assign o_irq = r_reg.irq;
  assign link.reg_rdata = r_reg.rdata;
  assign link.timer3_control_and_unit_timer_select = r_reg.t3;
  assign link.clr_first_timer = r_reg.clr1;
  assign link.clr_third_timer = r_reg.clr3;
  assign link.adc_start = r_reg.adc;
endmodule

// File: ccp_link_checker.sv
/*
  Assertions on the link between the device end and the partner end.
  Assumes one clock, i_ce held high and link signals passed in by name.
*/
`timescale 1ns/1ps
module ccp_link_checker (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  // watched link signals
  input wire logic [3:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic [15:0] first_timer_count,
  input wire logic [15:0] third_timer_count,
  input wire logic adc_enabled,
  input wire logic [7:0] timer3_control_and_unit_timer_select,
  input wire logic clr_first_timer,
  input wire logic clr_third_timer,
  input wire logic adc_start
);
  // short alias of the time base select byte
  wire [7:0] sel = timer3_control_and_unit_timer_select;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rstn);
  // a repeated pulse would clear the timer twice per match
  property p_clr1_once; clr_first_timer |=> !clr_first_timer; endproperty
  a_clr1_once: assert property (p_clr1_once) else $error("first clear too long");
  property p_clr3_once; clr_third_timer |=> !clr_third_timer; endproperty
  a_clr3_once: assert property (p_clr3_once) else $error("third clear too long");
  property p_clr1_zero; clr_first_timer |=> first_timer_count == 16'h0000; endproperty
  a_clr1_zero: assert property (p_clr1_zero) else $error("first timer not cleared");
  property p_clr3_zero; clr_third_timer |=> third_timer_count == 16'h0000; endproperty
  a_clr3_zero: assert property (p_clr3_zero) else $error("third timer not cleared");
  // converter start only with the converter already on
  property p_adc_en; adc_start |-> $past(adc_enabled); endproperty
  a_adc_en: assert property (p_adc_en) else $error("start with converter off");
  property p_adc_trig; adc_start |-> clr_first_timer || clr_third_timer; endproperty
  a_adc_trig: assert property (p_adc_trig) else $error("start without trigger");
  // reserved control bits of unit two read as zero
  property p_con2_rsvd;
    reg_rd && reg_addr == ccp_pkg::REG_CON[1] |=> reg_rdata[7:6] == 2'h0;
  endproperty
  a_con2_rsvd: assert property (p_con2_rsvd) else $error("reserved bits set");
  // cleared timer must be the selected time base
  property p_sel_first; clr_first_timer |-> !sel[6]; endproperty
  a_sel_first: assert property (p_sel_first) else $error("wrong timer cleared");
  property p_sel_third; clr_third_timer |-> sel[6] || sel[3]; endproperty
  a_sel_third: assert property (p_sel_third) else $error("wrong timer cleared");
endmodule

// File: ccp_link_if.sv
/*
  Link between the compare/PWM device end and its partner end (timers,
  converter, port latches and the software register port).
  Assumes one clock shared by both ends; no clocking block here.
*/
`timescale 1ns/1ps
interface ccp_link_if;
  // register access, partner to device, read data device to partner
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_rdata;
  // time bases and port state, partner to device
  logic [15:0] first_timer_count;
  logic [15:0] third_timer_count;
  logic [9:0] pwm_base;
  logic pwm_period;
  logic adc_enabled;
  logic [1:0] port_latch;
  logic [1:0] pin_direction_bit;
  // device to partner
  logic [7:0] timer3_control_and_unit_timer_select;
  logic clr_first_timer;
  logic clr_third_timer;
  logic adc_start;

  modport dev (
    input reg_addr, reg_wdata, reg_wr, reg_rd,
    input first_timer_count, third_timer_count, pwm_base, pwm_period,
    input adc_enabled, port_latch, pin_direction_bit,
    output reg_rdata, timer3_control_and_unit_timer_select,
    output clr_first_timer, clr_third_timer, adc_start
  );
  modport ptn (
    output reg_addr, reg_wdata, reg_wr, reg_rd,
    output first_timer_count, third_timer_count, pwm_base, pwm_period,
    output adc_enabled, port_latch, pin_direction_bit,
    input reg_rdata, timer3_control_and_unit_timer_select,
    input clr_first_timer, clr_third_timer, adc_start
  );
endinterface

// File: ccp_partner_end.sv
/*
  Partner end: first and third timers, PWM time base, converter enable,
  port latches and direction bits, and the software register port that
  forwards the lower half of its map to the device end.
  Assumes a bus master that follows the one-cycle strobe protocol.
*/
`timescale 1ns/1ps
module ccp_partner_end (
  // link to the device end
  ccp_link_if.ptn link,
  // clock, reset, enable
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  input wire logic i_ce,
  // software register port
  input wire logic [4:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // converter start
  output logic o_adc_start
);
  typedef struct packed {
    logic [7:0] ctl;    // timer run and converter enable bits
    logic [1:0] port;   // port data latches, untouched by the device
    logic [1:0] dir;    // pin direction bits, 1 is input
    logic [7:0] pr2;    // PWM period
    logic [15:0] t1;    // first timer
    logic [15:0] t3;    // third timer
    logic [9:0] base;   // PWM time base with two sub-bits
    logic period;       // period start pulse
    logic [7:0] rdata;  // local read answer
    logic dev_rd;       // last read went to the device
    logic adc;          // converter start to the user side
  } ptn_state_t;

  ptn_state_t r_reg;
  ptn_state_t r_next;
  logic local_sel;
  logic [3:0] loc;

  assign local_sel = i_addr[ccp_pkg::HOST_SEL_BIT];
  assign loc = i_addr[3:0];

  // lower half of the map passes straight through to the device
  assign link.reg_addr = loc;
  assign link.reg_wdata = i_wdata;
  assign link.reg_wr = i_wr && !local_sel;
  assign link.reg_rd = i_rd && !local_sel;

  // timers, time base and local registers
  always_comb begin
    r_next = r_reg;
    r_next.period = 1'b0;
    r_next.rdata = '0;
    r_next.dev_rd = i_rd && !local_sel;
    r_next.adc = link.adc_start;
    // timers count every cycle while their run bits are set, clears win
    if (link.clr_first_timer) begin
      r_next.t1 = '0;
    end else if (r_reg.ctl[ccp_pkg::HCTL_T1_RUN]) begin
      r_next.t1 = r_reg.t1 + 16'h0001;
    end
    if (link.clr_third_timer) begin
      r_next.t3 = '0;
    end else if (link.timer3_control_and_unit_timer_select[ccp_pkg::T3_RUN_BIT]) begin
      r_next.t3 = r_reg.t3 + 16'h0001;
    end
    // PWM time base wraps after the last sub-step of the period
    if (r_reg.ctl[ccp_pkg::HCTL_T2_RUN]) begin
      if (r_reg.base[9:2] == r_reg.pr2 && r_reg.base[1:0] == ccp_pkg::PWM_SUB_LAST) begin
        r_next.base = '0;
        r_next.period = 1'b1;
      end else begin
        r_next.base = r_reg.base + 10'h001;
      end
    end
    // local writes; software sets direction bits
    if (i_wr && local_sel) begin
      unique case (loc)
        ccp_pkg::HREG_CTL: r_next.ctl = i_wdata;
        ccp_pkg::HREG_PORT: r_next.port = i_wdata[1:0];
        ccp_pkg::HREG_DIR: r_next.dir = i_wdata[1:0];
        ccp_pkg::HREG_PR2: r_next.pr2 = i_wdata;
        ccp_pkg::HREG_T1_LO: r_next.t1[7:0] = i_wdata;
        ccp_pkg::HREG_T1_HI: r_next.t1[15:8] = i_wdata;
        ccp_pkg::HREG_T3_LO: r_next.t3[7:0] = i_wdata;
        ccp_pkg::HREG_T3_HI: r_next.t3[15:8] = i_wdata;
        default: r_next.ctl = r_next.ctl; // unmapped, ignored
      endcase
    end
    // local reads, unmapped give zero
    if (i_rd && local_sel) begin
      unique case (loc)
        ccp_pkg::HREG_CTL: r_next.rdata = r_reg.ctl;
        ccp_pkg::HREG_PORT: r_next.rdata = {6'h00, r_reg.port};
        ccp_pkg::HREG_DIR: r_next.rdata = {6'h00, r_reg.dir};
        ccp_pkg::HREG_PR2: r_next.rdata = r_reg.pr2;
        ccp_pkg::HREG_T1_LO: r_next.rdata = r_reg.t1[7:0];
        ccp_pkg::HREG_T1_HI: r_next.rdata = r_reg.t1[15:8];
        ccp_pkg::HREG_T3_LO: r_next.rdata = r_reg.t3[7:0];
        ccp_pkg::HREG_T3_HI: r_next.rdata = r_reg.t3[15:8];
        default: r_next.rdata = '0;
      endcase
    end
  end

  // state register; pins start as inputs
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      r_reg <= '0;
      r_reg.dir <= ccp_pkg::DIR_RESET;
    end else if (i_ce) begin
      r_reg <= r_next;
    end
  end

  // read answer picks the device flop or the local flop
  assign o_rdata = r_reg.dev_rd ? link.reg_rdata : r_reg.rdata;
  assign o_adc_start = r_reg.adc;
  assign link.first_timer_count = r_reg.t1;
  assign link.third_timer_count = r_reg.t3;
  assign link.pwm_base = r_reg.base;
  assign link.pwm_period = r_reg.period;
  assign link.adc_enabled = r_reg.ctl[ccp_pkg::HCTL_ADC_EN];
  assign link.port_latch = r_reg.port;
  assign link.pin_direction_bit = r_reg.dir;
endmodule

// File: ccp_pkg.sv
/*
  Shared constants for the compare/PWM unit pair and its partner logic:
  widths, mode codes, register indices, field positions and the timer
  select decoder.
  Assumes both ends and the link interface are compiled after it.
*/
package ccp_pkg;

  // widths
  localparam int VAL_W = 16;
  localparam int DUTY_W = 10;
  localparam int MODE_W = 4;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int NUM_UNITS = 2;

  // mode field codes
  localparam logic [3:0] MODE_OFF = 4'h0;
  localparam logic [3:0] MODE_TOGGLE = 4'h2;
  localparam logic [3:0] MODE_SET_HI = 4'h8;
  localparam logic [3:0] MODE_SET_LO = 4'h9;
  localparam logic [3:0] MODE_SW_INT = 4'hA;
  localparam logic [3:0] MODE_TRIGGER = 4'hB;
  localparam logic [1:0] MODE_CMP_PFX = 2'h2;
  localparam logic [1:0] MODE_PWM_PFX = 2'h3;

  // device register indices, one per unit where arrays
  localparam logic [3:0] REG_T3 = 4'h0;
  localparam logic [1:0][3:0] REG_LO = {4'h4, 4'h1};
  localparam logic [1:0][3:0] REG_HI = {4'h5, 4'h2};
  localparam logic [1:0][3:0] REG_CON = {4'h6, 4'h3};
  localparam logic [3:0] REG_FLAG = 4'h7;
  localparam logic [3:0] REG_FLAG_CLR = 4'h8;
  localparam logic [3:0] REG_FLAG_EN = 4'h9;

  // control register fields
  localparam int CON_MODE_LSB = 0;
  localparam int CON_DUTY_LSB = 4;
  localparam logic [1:0][7:0] CON_MASK = {8'h3F, 8'hFF};
  localparam int T3_RUN_BIT = 0;
  localparam int T3_SEL_LO_BIT = 3;
  localparam int T3_SEL_HI_BIT = 6;

  // partner register indices (local address, bit 4 of bus address set)
  localparam int HOST_SEL_BIT = 4;
  localparam logic [3:0] HREG_CTL = 4'h0;
  localparam logic [3:0] HREG_PORT = 4'h1;
  localparam logic [3:0] HREG_DIR = 4'h2;
  localparam logic [3:0] HREG_PR2 = 4'h3;
  localparam logic [3:0] HREG_T1_LO = 4'h4;
  localparam logic [3:0] HREG_T1_HI = 4'h5;
  localparam logic [3:0] HREG_T3_LO = 4'h6;
  localparam logic [3:0] HREG_T3_HI = 4'h7;
  localparam int HCTL_T1_RUN = 0;
  localparam int HCTL_ADC_EN = 1;
  localparam int HCTL_T2_RUN = 2;
  localparam logic [1:0] DIR_RESET = 2'h3;
  localparam logic [1:0] PWM_SUB_LAST = 2'h3;

  // true when unit u takes its time base from the third timer
  function automatic logic uses_timer3(input int u, input logic [7:0] t3);
    if (t3[T3_SEL_HI_BIT]) begin
      return 1'b1;
    end
    return t3[T3_SEL_LO_BIT] && (u == 1);
  endfunction

endpackage

// File: compare_match_unit_tb.sv
/*
  Self-checking bench: both ends joined by the link, driven on the
  software register port. Assumes one-cycle strobes and i_ce held high.
*/
`timescale 1ns/1ps
module compare_match_unit_tb;
  // bench clock, reset and bus
  logic i_ref_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic [4:0] i_addr = 5'h00;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  // observed outputs
  logic [7:0] o_rdata;
  logic o_adc_start;
  logic [1:0] o_pin;
  logic [1:0] o_pin_oe;
  logic o_irq;
  int err_total = 0;
  int total_checks = 0;
  int adc_cnt = 0;
  // compare codes and pin level expected after each match
  logic [7:0] modes [4] = '{8'h08, 8'h09, 8'h02, 8'h0A};
  logic pins [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
  ccp_link_if link ();
  ccp_device_end i_ccp_device_end (.link(link), .i_ref_clk(i_ref_clk), .i_rstn(i_rstn),
    .i_ce(1'b1), .o_pin(o_pin), .o_pin_oe(o_pin_oe), .o_irq(o_irq));
  ccp_partner_end i_ccp_partner_end (.link(link), .i_ref_clk(i_ref_clk), .i_rstn(i_rstn),
    .i_ce(1'b1), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .o_adc_start(o_adc_start));
  ccp_link_checker i_ccp_link_checker (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn),
    .reg_addr(link.reg_addr), .reg_rd(link.reg_rd), .reg_rdata(link.reg_rdata),
    .first_timer_count(link.first_timer_count), .third_timer_count(link.third_timer_count),
    .adc_enabled(link.adc_enabled),
    .timer3_control_and_unit_timer_select(link.timer3_control_and_unit_timer_select),
    .clr_first_timer(link.clr_first_timer), .clr_third_timer(link.clr_third_timer),
    .adc_start(link.adc_start));
  always #5 i_ref_clk = ~i_ref_clk;
  // count converter starts seen at the port
  always @(posedge i_ref_clk) begin
    adc_cnt <= adc_cnt + int'(o_adc_start === 1'b1);
  end
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // one-cycle write strobe, one idle cycle after it
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge i_ref_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [4:0] a, input logic [7:0] exp);
    @(posedge i_ref_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    #1 check($sformatf("reg_%h", a), o_rdata, exp);
  endtask
  // timers stopped: load count so it equals 16'h1234 once and stays
  task automatic hit(input int u, input logic [7:0] m);
    logic [4:0] t;
    t = (u == 0) ? 5'h14 : 5'h16;
    wr({1'b0, ccp_pkg::REG_HI[u]}, 8'h12);
    wr({1'b0, ccp_pkg::REG_LO[u]}, 8'h34);
    wr(t + 5'h01, 8'h00);
    wr(t, 8'h00);
    wr({1'b0, ccp_pkg::REG_CON[u]}, m);
    wr(5'h08, 8'h03);
    wr(t + 5'h01, 8'h12);
    wr(t, 8'h34);
    repeat (6) @(posedge i_ref_clk);
    #1;
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (20) @(posedge i_ref_clk);
    i_rstn <= 1'b1;
    #1 check("oe", {6'h00, o_pin_oe}, 8'h00);
    rd(5'h12, 8'h03);
    wr(5'h06, 8'hFF);
    rd(5'h06, 8'h3F);
    wr(5'h06, 8'h00);
    rd(5'h1F, 8'h00);
    wr(5'h12, 8'h00);
    // both pins driven once the direction bits are cleared
    repeat (2) @(posedge i_ref_clk);
    #1 check("oe", {6'h00, o_pin_oe}, 8'h03);
    wr(5'h11, 8'h00);
    wr(5'h09, 8'h03);
    wr(5'h00, 8'h08);
    for (int k = 0; k < 4; k++) begin
      hit(0, modes[k]);
      check("pin0", {7'h00, o_pin[0]}, {7'h00, pins[k]});
      check("irq", {7'h00, o_irq}, 8'h01);
      rd(5'h07, 8'h01);
    end
    hit(0, 8'h0B);
    rd(5'h14, 8'h00);
    wr(5'h14, 8'h55);
    wr(5'h10, 8'h02);
    hit(1, 8'h0B);
    rd(5'h16, 8'h00);
    rd(5'h14, 8'h55);
    check("adc", 8'(adc_cnt), 8'h01);
    wr(5'h10, 8'h00);
    hit(1, 8'h0B);
    check("adc", 8'(adc_cnt), 8'h01);
    wr(5'h09, 8'h00);
    hit(1, 8'h0A);
    check("irq", {7'h00, o_irq}, 8'h00);
    rd(5'h07, 8'h02);
    wr(5'h09, 8'h02);
    repeat (2) @(posedge i_ref_clk);
    #1 check("irq", {7'h00, o_irq}, 8'h01);
    wr(5'h08, 8'h02);
    repeat (2) @(posedge i_ref_clk);
    #1 check("irq", {7'h00, o_irq}, 8'h00);
    hit(1, 8'h08);
    check("pin1", {7'h00, o_pin[1]}, 8'h01);
    wr(5'h11, 8'h02);
    wr(5'h06, 8'h00);
    wr(5'h06, 8'h02);
    repeat (2) @(posedge i_ref_clk);
    #1 check("pin1", {7'h00, o_pin[1]}, 8'h00);
    rd(5'h11, 8'h02);
    // unit one in PWM, period of four base steps, duty beyond the period
    wr(5'h01, 8'hFF);
    wr(5'h03, 8'h3C);
    wr(5'h10, 8'h04);
    repeat (12) @(posedge i_ref_clk);
    #1 check("pin0", {7'h00, o_pin[0]}, 8'h01);
    rd(5'h02, 8'hFF);
    // zero duty keeps the pin low from the next period on
    wr(5'h01, 8'h00);
    wr(5'h03, 8'h0C);
    repeat (12) @(posedge i_ref_clk);
    #1 check("pin0", {7'h00, o_pin[0]}, 8'h00);
    rd(5'h02, 8'h00);
    final_report();
  end
  // watchdog well beyond the few hundred cycles the tests need
  initial begin
    repeat (5000) @(posedge i_ref_clk);
    err_total++;
    final_report();
  end
endmodule
